/* logic/scmr_pkg.sv */
// package for the serial configuration memory read-out block
`default_nettype none
package scmr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BIT_W = 3;
    localparam int MEM_WORDS = 4096;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 12'hfff;
    localparam logic [BIT_W-1:0] BIT_RST = 3'h0;
    localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h001;
    localparam logic [BIT_W-1:0] BIT_STEP = 3'h1;
    localparam logic [DATA_W-1:0] WORD_RST = 8'h00;

    typedef enum logic [3:0] {
        SCMR_IDLE = 4'b0001,
        SCMR_STANDBY = 4'b0010,
        SCMR_READ = 4'b0100,
        SCMR_DONE = 4'b1000
    } scmr_state_e;

    // pin set from the configuration master
    typedef struct packed {
        logic readout_clock;
        logic chip_enable_n;
        logic reset_oe;
        logic serial_program_enable_n;
        logic device_select_bit;
        logic data_in;
    } scmr_pins_s;

    // programming-side write port into the array
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } scmr_prog_s;
endpackage
`default_nettype wire

/* logic/scmr_readout.sv */
// serial configuration memory read-out and mode control
//
// Summary of operation
// - reset/oe low clears address, floats data
// - chip enable high keeps counter off, floats
// - oe high with ce low enables output
// - later reset low clears regardless of ce
// - after last bit, float data line
// - power-up clears address counter automatically
// - clock advances address and bit counters
// - ce high disables counters, standby
// - ce ignored in programming mode
// - device select qualifies programming access
// - data open-collector in programming, tristate otherwise
// - reset/oe low also clears bit counter
// - standby keeps data floated despite oe
`timescale 1ns/1ps
`default_nettype none
module scmr_readout
    import scmr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire scmr_pins_s i_pins,
    input wire scmr_prog_s i_prog,
    output logic o_data,
    output logic o_data_oe,
    output logic o_cascade_enable_out_n,
    output logic o_standby,
    output logic o_program_mode,
    output logic o_selected
);

    ////////////////////////////////////////////////////////////////////////
    // storage array
    logic [DATA_W-1:0] mem [MEM_WORDS];

    ////////////////////////////////////////////////////////////////////////
    // shared decode and arithmetic

    // serial enable low selects programming mode
    function automatic logic scmr_in_prog(
        input scmr_pins_s pins
    );
        return ~pins.serial_program_enable_n;
    endfunction

    // programming access needs the select pin high
    function automatic logic scmr_in_select(
        input scmr_pins_s pins
    );
        return scmr_in_prog(pins) & pins.device_select_bit;
    endfunction

    // combined pin low is a reset only in configuration mode
    function automatic logic scmr_in_reset(
        input scmr_pins_s pins
    );
        return ~scmr_in_prog(pins) & ~pins.reset_oe;
    endfunction

    // ce low and oe high let the clock advance the counters
    function automatic logic scmr_can_run(
        input scmr_pins_s pins
    );
        return ~scmr_in_prog(pins) & ~pins.chip_enable_n & pins.reset_oe;
    endfunction

    // ce high parks the part in standby outside programming
    function automatic logic scmr_in_standby(
        input scmr_pins_s pins
    );
        return ~scmr_in_prog(pins) & pins.chip_enable_n;
    endfunction

    // address step, wraps at the top of the array
    function automatic logic [ADDR_W-1:0] scmr_addr_step(
        input logic [ADDR_W-1:0] addr
    );
        return addr + ADDR_STEP;
    endfunction

    // bit step, wraps back to bit 0 after the last bit of a byte
    function automatic logic [BIT_W-1:0] scmr_bit_step(
        input logic [BIT_W-1:0] bit_pos
    );
        return bit_pos + BIT_STEP;
    endfunction

    // last bit of the current byte
    function automatic logic scmr_byte_end(
        input logic [BIT_W-1:0] bit_pos
    );
        return bit_pos == BIT_LAST;
    endfunction

    // bit 0 of a byte goes out first
    function automatic logic scmr_pick(
        input logic [DATA_W-1:0] word,
        input logic [BIT_W-1:0] bit_pos
    );
        return word[bit_pos];
    endfunction

    // final bit of the whole array
    function automatic logic scmr_is_last(
        input logic [ADDR_W-1:0] addr,
        input logic [BIT_W-1:0] bit_pos
    );
        return (addr == ADDR_LAST) && scmr_byte_end(bit_pos);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin decode and clock edge detect
    logic clk_pin_reg;
    logic clk_pin_next;
    logic clk_rise;
    logic prog_mode;
    logic sel_prog;
    logic rst_low;
    logic run_en;

    assign prog_mode = scmr_in_prog(i_pins);
    assign sel_prog = scmr_in_select(i_pins);
    assign rst_low = scmr_in_reset(i_pins);
    // ce only counts outside programming mode
    assign run_en = scmr_can_run(i_pins);
    assign clk_rise = i_pins.readout_clock & ~clk_pin_reg;

    always_comb begin
        clk_pin_next = i_pins.readout_clock;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_pin_reg <= 1'b0;
        end else begin
            clk_pin_reg <= clk_pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming write into array, device select qualified
    always_ff @(posedge i_clk) begin
        if (sel_prog && i_prog.we) begin
            mem[i_prog.addr] <= i_prog.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-out state and counters
    scmr_state_e state_reg;
    scmr_state_e state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [BIT_W-1:0] bit_reg;
    logic [BIT_W-1:0] bit_next;
    logic [DATA_W-1:0] word_reg;
    logic [DATA_W-1:0] word_next;
    logic data_reg;
    logic data_next;
    logic oe_reg;
    logic oe_next;
    logic ceo_reg;
    logic ceo_next;
    logic last_bit;
    logic byte_end;
    logic [ADDR_W-1:0] step_addr;
    logic [BIT_W-1:0] step_bit;
    logic [DATA_W-1:0] step_word;
    logic step_data;

    ////////////////////////////////////////////////////////////////////////
    // position one readout clock ahead
    always_comb begin
        last_bit = scmr_is_last(addr_reg, bit_reg);
        byte_end = scmr_byte_end(bit_reg);
        step_bit = scmr_bit_step(bit_reg);
        step_addr = addr_reg;
        step_word = word_reg;
        if (byte_end) begin
            step_addr = scmr_addr_step(addr_reg);
            step_word = mem[step_addr];
        end
        step_data = scmr_pick(step_word, step_bit);
    end

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        bit_next = bit_reg;
        word_next = word_reg;
        data_next = data_reg;
        oe_next = 1'b0;
        ceo_next = ceo_reg;
        if (prog_mode) begin
            // open-collector: drive only a low, only when selected
            state_next = SCMR_IDLE;
            if (clk_rise && sel_prog) begin
                bit_next = step_bit;
                addr_next = step_addr;
            end
            data_next = 1'b0;
            oe_next = sel_prog & ~i_pins.data_in;
        end else if (rst_low) begin
            state_next = SCMR_IDLE;
            addr_next = ADDR_RST;
            bit_next = BIT_RST;
            ceo_next = 1'b1;
            word_next = mem[ADDR_RST];
        end else begin
            case (state_reg)
                SCMR_IDLE, SCMR_STANDBY, SCMR_READ: begin
                    if (i_pins.chip_enable_n) begin
                        state_next = SCMR_STANDBY;
                    end else if (run_en) begin
                        state_next = SCMR_READ;
                        oe_next = 1'b1;
                        data_next = scmr_pick(word_reg, bit_reg);
                        if (clk_rise) begin
                            if (last_bit) begin
                                state_next = SCMR_DONE;
                                ceo_next = 1'b0;
                                oe_next = 1'b0;
                            end else begin
                                bit_next = step_bit;
                                addr_next = step_addr;
                                word_next = step_word;
                                data_next = step_data;
                            end
                        end
                    end
                end
                SCMR_DONE: begin
                    oe_next = 1'b0;
                    ceo_next = 1'b0;
                end
                default: begin
                    state_next = SCMR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= SCMR_IDLE;
            addr_reg <= ADDR_RST;
            bit_reg <= BIT_RST;
            word_reg <= WORD_RST;
            data_reg <= 1'b0;
            oe_reg <= 1'b0;
            ceo_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            bit_reg <= bit_next;
            word_reg <= word_next;
            data_reg <= data_next;
            oe_reg <= oe_next;
            ceo_reg <= ceo_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags
    logic standby_reg;
    logic standby_next;
    logic prog_reg;
    logic prog_next;
    logic sel_reg;
    logic sel_next;

    always_comb begin
        standby_next = scmr_in_standby(i_pins);
        prog_next = prog_mode;
        sel_next = sel_prog;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            standby_reg <= 1'b0;
            prog_reg <= 1'b0;
            sel_reg <= 1'b0;
        end else begin
            standby_reg <= standby_next;
            prog_reg <= prog_next;
            sel_reg <= sel_next;
        end
    end

    assign o_data = data_reg;
    assign o_data_oe = oe_reg;
    assign o_cascade_enable_out_n = ceo_reg;
    assign o_standby = standby_reg;
    assign o_program_mode = prog_reg;
    assign o_selected = sel_reg;

endmodule // scmr_readout
`default_nettype wire

/* sim/scmr_readout_checker.sv */
// port assertions for the read-out block
`timescale 1ns/1ps
`default_nettype none
module scmr_readout_checker
    import scmr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire scmr_pins_s i_pins,
    input wire scmr_prog_s i_prog,
    input wire logic o_data,
    input wire logic o_data_oe,
    input wire logic o_cascade_enable_out_n,
    input wire logic o_standby,
    input wire logic o_program_mode,
    input wire logic o_selected
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic cfg = i_pins.serial_program_enable_n;
    wire logic ce_n = i_pins.chip_enable_n;
    rst_float_a: assert property ((cfg && !i_pins.reset_oe)[*2]
        |-> !o_data_oe && o_cascade_enable_out_n) else $error("driven in reset");
    standby_float_a: assert property ((cfg && ce_n)[*2]
        |-> !o_data_oe && o_standby) else $error("driven in standby");
    ce_ignored_a: assert property ((!cfg)[*2]
        |-> !o_standby && o_program_mode) else $error("ce acts in prog mode");
    cfg_mode_a: assert property (cfg[*2]
        |-> !o_program_mode && !o_selected) else $error("prog mode in config");
    select_a: assert property ((!cfg && i_pins.device_select_bit)[*2]
        |-> o_selected) else $error("select missed");
    oe_cause_a: assert property ($rose(o_data_oe) && cfg
        |-> $past(i_pins.reset_oe) && !$past(ce_n)) else $error("oe without cause");
    hold_bit_a: assert property ((o_data_oe && cfg && !$rose(i_pins.readout_clock))[*3]
        |-> $stable(o_data)) else $error("bit moved without clock");
    end_float_a: assert property (!o_cascade_enable_out_n
        |-> !o_data_oe) else $error("driven after last bit");
    cover property ($rose(o_data_oe));
    cover property ($fell(o_cascade_enable_out_n));
    cover property ($rose(o_selected));
endmodule // scmr_readout_checker
bind scmr_readout scmr_readout_checker chk (.*);
`default_nettype wire

/* sim/scmr_master_model.sv */
// configuration master driving the read-out pins
`timescale 1ns/1ps
`default_nettype none
module scmr_master_model (
    input wire logic i_clk,
    output logic o_rclk,
    output logic o_ce_n,
    output logic o_roe
);
    initial begin
        o_rclk = 1'h0;
        o_ce_n = 1'h1;
        o_roe = 1'h0;
    end
    // clock stands low outside frames
    task automatic rise();
        @(posedge i_clk);
        o_rclk <= 1'h1;
        @(posedge i_clk);
        o_rclk <= 1'h0;
    endtask
    task automatic set(input logic ce_n, input logic roe);
        @(posedge i_clk);
        o_ce_n <= ce_n;
        o_roe <= roe;
    endtask
endmodule // scmr_master_model
`default_nettype wire

/* sim/scmr_readout_tb.sv */
// self-checking bench for the read-out block
`timescale 1ns/1ps
`default_nettype none
module scmr_readout_tb
    import scmr_pkg::*;
;
    logic i_clk = 1'h0, i_rst_b = 1'h0, sep_n = 1'h1, dsel = 1'h0, smp = 1'h0;
    logic rclk, ce_n, roe, o_data, o_data_oe, cascade_enable_out_n, sb, pm, sel;
    logic [7:0] mem [MEM_WORDS];
    logic [5:0] q [$];
    logic [5:0] e;
    int err_count = 0, num_checks = 0;
    scmr_pins_s pins;
    scmr_prog_s prog = '0;
    // pull-up on the shared data wire
    assign pins = {rclk, ce_n, roe, sep_n, dsel, ~(o_data_oe & ~o_data)};
    always #10 i_clk = ~i_clk;
    scmr_master_model mdl (.i_clk(i_clk), .o_rclk(rclk), .o_ce_n(ce_n), .o_roe(roe));
    scmr_readout dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(pins), .i_prog(prog),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_cascade_enable_out_n(cascade_enable_out_n),
        .o_standby(sb), .o_program_mode(pm), .o_selected(sel));
    task automatic check(input logic [5:0] s, input logic [5:0] x);
        num_checks++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] outputs expected %h seen %h", x, s);
        end
    endtask
    task automatic note(input logic [5:0] x);
        repeat (2) @(posedge i_clk);
        q.push_back(x);
        smp <= 1'h1;
        @(posedge i_clk);
        smp <= 1'h0;
    endtask
    // data bit is masked while the driver is off
    always @(negedge i_clk) begin
        if (smp) begin
            e = q.pop_front();
            check({o_data, o_data_oe, cascade_enable_out_n, sb, pm, sel} & {e[4], 5'h1f}, e & {e[4], 5'h1f});
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_clk);
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(6704));
        foreach (mem[a]) mem[a] = 8'($urandom);
        note(6'h08);
        i_rst_b <= 1'h1;
        sep_n <= 1'h0;
        dsel <= 1'h1;
        note(6'h0b);
        for (int a = 0; a < MEM_WORDS; a++) begin
            @(posedge i_clk);
            prog <= {1'h1, a[ADDR_W-1:0], mem[a]};
        end
        @(posedge i_clk);
        prog <= '0;
        dsel <= 1'h0;
        note(6'h0a);
        prog <= {1'h1, ADDR_RST, ~mem[0]};
        @(posedge i_clk);
        prog <= '0;
        sep_n <= 1'h1;
        mdl.set(1'h1, 1'h0);
        note(6'h0c);
        mdl.set(1'h1, 1'h1);
        note(6'h0c);
        mdl.set(1'h0, 1'h1);
        note({mem[0][0], 5'h18});
        for (int i = 1; i < 16; i++) begin
            mdl.rise();
            note({mem[i/8][i%8], 5'h18});
        end
        mdl.set(1'h1, 1'h1);
        mdl.rise();
        note(6'h0c);
        mdl.set(1'h0, 1'h1);
        note({mem[1][7], 5'h18});
        mdl.set(1'h1, 1'h0);
        note(6'h0c);
        mdl.set(1'h0, 1'h1);
        note({mem[0][0], 5'h18});
        for (int i = 1; i <= 8*MEM_WORDS; i++) begin
            mdl.rise();
            if (i >= 8*MEM_WORDS-8)
                note(i < 8*MEM_WORDS ? {mem[MEM_WORDS-1][i%8], 5'h18} : 6'h00);
        end
        print_verdict();
    end
endmodule // scmr_readout_tb
`default_nettype wire
